// >>> rtl/sca_pkg.sv
// Shared constants and types for the checked SPI access block
package sca_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [3:0]  CMD_READ_CRC   = 4'hb;
  localparam logic [3:0]  CMD_WRITE_CRC  = 4'ha;
  localparam logic [3:0]  CMD_WRITE_SAFE = 4'hc;

  // ==========================================================================
  // Checksum
  localparam logic [15:0] CRC_PRESET     = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'h8005;

  // ==========================================================================
  // Address map
  localparam logic [11:0] RAM_FIRST      = 12'h400;
  localparam logic [11:0] RAM_LAST       = 12'hbff;
  localparam logic [11:0] ADDR_BYTE_STEP = 12'h001;
  localparam logic [11:0] ADDR_WORD_STEP = 12'h004;
  localparam logic [1:0]  WORD_ALIGN     = 2'h0;
  localparam logic [1:0]  LANE_LAST      = 2'h3;

  // ==========================================================================
  // Field lengths, as last bit index within a field or as a count of bytes
  localparam logic [3:0]  CMD_LAST_BIT   = 4'h3;
  localparam logic [3:0]  HDR_LAST_BIT   = 4'hf;
  localparam logic [3:0]  BYTE_LAST_BIT  = 4'h7;
  localparam logic [3:0]  CRC_LAST_BIT   = 4'hf;
  localparam logic [9:0]  SAFE_RAM_BYTES = 10'h004;
  localparam logic [9:0]  SAFE_REG_BYTES = 10'h001;
  localparam logic [9:0]  ONE_BYTE_LEFT  = 10'h001;

  // ==========================================================================
  // Frame phases on the link side
  typedef enum logic [2:0] {PH_HDR, PH_CNT, PH_DATA, PH_CRC, PH_IDLE} sca_phase_t;

endpackage

// >>> rtl/sca_crc_step.sv
// One serial step of the frame checksum
`timescale 1ns/100ps
module sca_crc_step (
  // Checksum in and out
  input  wire logic [15:0] crcIn,
  input  wire logic        bitIn,
  output logic      [15:0] crcOut
);
  import sca_pkg::*;

  logic fb;

  // ==========================================================================
  // MSB-first shift with generator feedback
  assign fb     = crcIn[15] ^ bitIn;
  assign crcOut = {crcIn[14:0], 1'b0} ^ (fb ? CRC_POLY : '0);
endmodule

// >>> rtl/sca_access_top.sv
// Checked SPI command decoder with control register space and message RAM
`timescale 1ns/100ps

// Operation
// - Safe register write: cmd, addr, byte, CRC
// - Safe register write waits for matching CRC
// - Bad safe register write: keep, flag mismatch
// - Early deselect in CRC command: framing flag
// - Checked read: cmd, addr, count, data, CRC
// - RAM addresses forced to word alignment
// - Fetch a RAM word per four bytes
// - Checked reads raise no mismatch flag
// - Checked write: cmd, addr, count, data, CRC
// - Checked RAM write commits each full word
// - Partial RAM word is dropped
// - Checked write mismatch flags, keeps words
// - Safe RAM write: cmd, addr, word, CRC
// - Safe RAM write waits for matching CRC
// - Bad safe RAM write: keep, flag mismatch
// - Checksum preset to ones at select
// - Generator polynomial 0x8005
// - Checksum covers command, address, count, data
// - Mismatch stores computed checksum
module sca_access_top
  import sca_pkg::*;
#(
  parameter int RAM_WORDS = 512,
  parameter int REG_BYTES = 64
) (
  // System side
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clearFlags,
  // Serial link
  input  wire logic        sck,
  input  wire logic        chipSelectLow,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdoOe,
  // Status
  output logic             crcMismatchFlag,
  output logic             crcFramingErrorFlag,
  output logic      [15:0] crcResult
);
  import sca_pkg::*;

  localparam int RAM_AW = $clog2(RAM_WORDS);
  localparam int REG_AW = $clog2(REG_BYTES);

  // ==========================================================================
  // Link-side state
  typedef struct packed {
    sca_phase_t  phase;
    logic [3:0]  bitCnt;
    logic [3:0]  cmd;
    logic        cmdKnown;
    logic        isRam;
    logic [11:0] addr;
    logic [11:0] startAddr;
    logic [15:0] shiftIn;
    logic [9:0]  bytesLeft;
    logic [1:0]  lane;
    logic [15:0] crc;
    logic [31:0] word;
    logic        byteTog;
    logic [11:0] evAddr;
    logic [31:0] evData;
    logic        fetchTog;
    logic [11:0] fetchAddr;
    logic        endTog;
    logic        crcOk;
    logic        crcDone;
  } sca_link_t;

  // ==========================================================================
  // System-side state
  typedef struct packed {
    logic [2:0]                    csS;
    logic [2:0]                    byteS;
    logic [2:0]                    fetchS;
    logic [2:0]                    endS;
    logic                          byteSeen;
    logic                          fetchSeen;
    logic                          endSeen;
    logic                          inFrame;
    logic                          linkInit;
    logic [31:0]                   rdWord;
    logic [RAM_WORDS-1:0][31:0]    ram;
    logic [REG_BYTES-1:0][7:0]     regs;
    logic                          mismatch;
    logic                          framing;
    logic [15:0]                   crcResult;
  } sca_sys_t;

  sca_link_t lk_q;
  sca_link_t lk_d;
  sca_sys_t  sy_q;
  sca_sys_t  sy_d;
  logic      startPend_q;
  logic      stepBit;
  logic      isRead;
  logic [15:0] crcSeed;
  logic [15:0] crcNext;
  logic [15:0] hdrIn;

  function automatic logic [11:0] stepAddr(input logic [11:0] a, input logic ram, input logic [11:0] step);
    logic [11:0] n;
    n = 12'(a + step);
    // RAM wraps from its top back to its base
    if (ram && n > RAM_LAST) begin
      n = 12'(n - (RAM_LAST - RAM_FIRST) - ADDR_BYTE_STEP);
    end
    return n;
  endfunction

  function automatic logic [RAM_AW-1:0] ramIdx(input logic [11:0] a);
    logic [11:0] off;
    off = 12'(a - RAM_FIRST);
    return off[RAM_AW+1:2];
  endfunction

  // ==========================================================================
  // Link side: frame start marker, cleared by the first clock of the frame
  always_ff @(posedge sck or posedge chipSelectLow) begin
    if (chipSelectLow) begin
      startPend_q <= 1'b1;
    end else begin
      startPend_q <= 1'b0;
    end
  end

  assign isRead  = lk_q.cmd == CMD_READ_CRC;
  assign crcSeed = startPend_q ? CRC_PRESET : lk_q.crc;
  assign stepBit = (!startPend_q && isRead && lk_q.phase == PH_DATA) ? lk_q.word[31] : sdi;
  assign hdrIn   = {lk_q.shiftIn[14:0], sdi};

  sca_crc_step uCrc (
    .crcIn  (crcSeed),
    .bitIn  (stepBit),
    .crcOut (crcNext)
  );

  always_comb begin
    lk_d = lk_q;
    if (startPend_q) begin
      lk_d.phase    = PH_HDR;
      lk_d.bitCnt   = '0;
      lk_d.cmdKnown = 1'b0;
      lk_d.crcDone  = 1'b0;
      lk_d.crcOk    = 1'b0;
      lk_d.shiftIn  = '0;
      if (sy_q.linkInit) begin
        lk_d.byteTog  = 1'b0;
        lk_d.fetchTog = 1'b0;
        lk_d.endTog   = 1'b0;
      end
    end
    lk_d.shiftIn = {lk_d.shiftIn[14:0], sdi};
    lk_d.bitCnt  = 4'(lk_d.bitCnt + 4'h1);
    unique case (startPend_q ? PH_HDR : lk_q.phase)
      PH_HDR: begin
        lk_d.crc = crcNext;
        if (lk_d.bitCnt == 4'(CMD_LAST_BIT + 4'h1)) begin
          lk_d.cmd      = lk_d.shiftIn[3:0];
          lk_d.cmdKnown = 1'b1;
        end
        if (lk_q.bitCnt == HDR_LAST_BIT && !startPend_q) begin
          lk_d.isRam     = hdrIn[11:0] >= RAM_FIRST && hdrIn[11:0] <= RAM_LAST;
          lk_d.addr      = lk_d.isRam ? {hdrIn[11:2], WORD_ALIGN} : hdrIn[11:0];
          lk_d.startAddr = lk_d.addr;
          lk_d.bitCnt    = '0;
          lk_d.lane      = '0;
          if (lk_q.cmd == CMD_READ_CRC || lk_q.cmd == CMD_WRITE_CRC) begin
            lk_d.phase = PH_CNT;
            if (lk_q.cmd == CMD_READ_CRC) begin
              lk_d.fetchAddr = lk_d.addr;
              lk_d.fetchTog  = !lk_q.fetchTog;
            end
          end else if (lk_q.cmd == CMD_WRITE_SAFE) begin
            lk_d.phase     = PH_DATA;
            lk_d.bytesLeft = lk_d.isRam ? SAFE_RAM_BYTES : SAFE_REG_BYTES;
          end else begin
            lk_d.phase = PH_IDLE;
          end
        end
      end
      PH_CNT: begin
        lk_d.crc = crcNext;
        if (lk_q.bitCnt == BYTE_LAST_BIT) begin
          lk_d.bitCnt    = '0;
          lk_d.bytesLeft = lk_q.isRam ? {hdrIn[7:0], 2'b00} : {2'b00, hdrIn[7:0]};
          lk_d.phase     = (lk_d.bytesLeft == '0) ? PH_CRC : PH_DATA;
          lk_d.shiftIn   = crcNext;
          if (isRead) begin
            lk_d.word      = sy_q.rdWord;
            lk_d.fetchAddr = stepAddr(lk_q.addr, lk_q.isRam, ADDR_WORD_STEP);
            lk_d.fetchTog  = !lk_q.fetchTog;
          end
        end
      end
      PH_DATA: begin
        lk_d.crc = crcNext;
        if (isRead) begin
          lk_d.word = {lk_q.word[30:0], 1'b0};
        end
        if (lk_q.bitCnt == BYTE_LAST_BIT) begin
          lk_d.bitCnt = '0;
          if (!isRead) begin
            lk_d.word = {lk_q.word[23:0], hdrIn[7:0]};
          end
          if (lk_q.cmd == CMD_WRITE_CRC) begin
            lk_d.evAddr  = lk_q.addr;
            lk_d.evData  = lk_d.word;
            lk_d.byteTog = !lk_q.byteTog;
          end
          if (isRead && lk_q.lane == LANE_LAST) begin
            lk_d.word      = sy_q.rdWord;
            lk_d.fetchAddr = stepAddr(lk_q.fetchAddr, lk_q.isRam, ADDR_WORD_STEP);
            lk_d.fetchTog  = !lk_q.fetchTog;
          end
          lk_d.addr      = stepAddr(lk_q.addr, lk_q.isRam, ADDR_BYTE_STEP);
          lk_d.lane      = 2'(lk_q.lane + 2'h1);
          lk_d.bytesLeft = 10'(lk_q.bytesLeft - ONE_BYTE_LEFT);
          if (lk_q.bytesLeft == ONE_BYTE_LEFT) begin
            lk_d.phase   = PH_CRC;
            lk_d.shiftIn = crcNext;
            if (lk_q.cmd == CMD_WRITE_SAFE) begin
              lk_d.evAddr = lk_q.startAddr;
              lk_d.evData = lk_d.word;
            end
          end
        end
      end
      PH_CRC: begin
        if (isRead) begin
          lk_d.shiftIn = {lk_q.shiftIn[14:0], 1'b0};
        end
        if (lk_q.bitCnt == CRC_LAST_BIT) begin
          lk_d.crcOk   = hdrIn == lk_q.crc;
          lk_d.crcDone = 1'b1;
          lk_d.endTog  = !lk_q.endTog;
          lk_d.phase   = PH_IDLE;
        end
      end
      PH_IDLE: begin
        lk_d.bitCnt = lk_q.bitCnt;
      end
    endcase
  end

  always_ff @(posedge sck) begin
    lk_q <= lk_d;
  end

  // Output bit changes on the falling edge, released at deselect
  always_ff @(negedge sck or posedge chipSelectLow) begin
    if (chipSelectLow) begin
      sdo   <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      sdo   <= lk_q.phase == PH_DATA ? lk_q.word[31] : lk_q.shiftIn[15];
      sdoOe <= isRead && (lk_q.phase == PH_DATA || lk_q.phase == PH_CRC);
    end
  end

  // ==========================================================================
  // System side: synchronised events and storage
  logic csStable;
  logic byteEv;
  logic fetchEv;
  logic endEv;
  logic frameEnd;
  logic badEnd;

  assign csStable = sy_q.csS[2] == sy_q.csS[1];
  assign byteEv   = sy_q.inFrame && sy_q.byteS[2] == sy_q.byteS[1] && sy_q.byteS[2] != sy_q.byteSeen;
  assign fetchEv  = sy_q.inFrame && sy_q.fetchS[2] == sy_q.fetchS[1] && sy_q.fetchS[2] != sy_q.fetchSeen;
  assign endEv    = sy_q.inFrame && sy_q.endS[2] == sy_q.endS[1] && sy_q.endS[2] != sy_q.endSeen;
  assign frameEnd = csStable && sy_q.csS[2] && sy_q.inFrame;
  assign badEnd   = endEv && !lk_q.crcOk && lk_q.cmd != CMD_READ_CRC;

  always_comb begin
    sy_d        = sy_q;
    sy_d.csS    = {sy_q.csS[1:0], chipSelectLow};
    sy_d.byteS  = {sy_q.byteS[1:0], lk_q.byteTog};
    sy_d.fetchS = {sy_q.fetchS[1:0], lk_q.fetchTog};
    sy_d.endS   = {sy_q.endS[1:0], lk_q.endTog};
    if (clearFlags) begin
      sy_d.mismatch = 1'b0;
      sy_d.framing  = 1'b0;
    end
    if (csStable && !sy_q.csS[2] && !sy_q.inFrame) begin
      sy_d.inFrame   = 1'b1;
      sy_d.byteSeen  = sy_q.linkInit ? 1'b0 : sy_q.byteS[2];
      sy_d.fetchSeen = sy_q.linkInit ? 1'b0 : sy_q.fetchS[2];
      sy_d.endSeen   = sy_q.linkInit ? 1'b0 : sy_q.endS[2];
    end
    if (byteEv) begin
      sy_d.byteSeen = sy_q.byteS[2];
      if (!lk_q.isRam) begin
        sy_d.regs[lk_q.evAddr[REG_AW-1:0]] = lk_q.evData[7:0];
      end else if (lk_q.evAddr[1:0] == LANE_LAST) begin
        sy_d.ram[ramIdx(lk_q.evAddr)] = lk_q.evData;
      end
    end
    if (fetchEv) begin
      sy_d.fetchSeen = sy_q.fetchS[2];
      if (lk_q.isRam) begin
        sy_d.rdWord = sy_q.ram[ramIdx(lk_q.fetchAddr)];
      end else begin
        for (int i = 0; i < 4; i++) begin
          sy_d.rdWord[31-8*i -: 8] = sy_q.regs[REG_AW'(lk_q.fetchAddr + 12'(i))];
        end
      end
    end
    if (endEv) begin
      sy_d.endSeen = sy_q.endS[2];
      if (lk_q.cmd == CMD_WRITE_SAFE && lk_q.crcOk) begin
        if (lk_q.isRam) begin
          sy_d.ram[ramIdx(lk_q.evAddr)] = lk_q.evData;
        end else begin
          sy_d.regs[lk_q.evAddr[REG_AW-1:0]] = lk_q.evData[7:0];
        end
      end
    end
    if (badEnd) begin
      sy_d.mismatch  = 1'b1;
      sy_d.crcResult = lk_q.crc;
    end
    if (frameEnd) begin
      sy_d.inFrame  = 1'b0;
      sy_d.linkInit = 1'b0;
      if (lk_q.cmdKnown && !lk_q.crcDone && (lk_q.cmd == CMD_READ_CRC || lk_q.cmd == CMD_WRITE_CRC
          || lk_q.cmd == CMD_WRITE_SAFE)) begin
        sy_d.framing = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sy_q          <= '0;
      sy_q.csS      <= 3'h7;
      sy_q.linkInit <= 1'b1;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign crcMismatchFlag     = sy_q.mismatch;
  assign crcFramingErrorFlag = sy_q.framing;
  assign crcResult           = sy_q.crcResult;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence safeEnd_s;
    endEv && lk_q.cmd == CMD_WRITE_SAFE;
  endsequence

  sequence badSafe_s;
    safeEnd_s ##0 !lk_q.crcOk;
  endsequence

  safe_bad_flag_a: assert property (badSafe_s |=> sy_q.mismatch && sy_q.crcResult == $past(lk_q.crc))
    else $error("bad safe write did not flag");
  safe_bad_keep_a: assert property (badSafe_s |=> $stable(sy_q.ram) && $stable(sy_q.regs))
    else $error("bad safe write changed storage");
  safe_ram_ok_a: assert property (safeEnd_s ##0 lk_q.crcOk && lk_q.isRam
      |=> sy_q.ram[ramIdx($past(lk_q.evAddr))] == $past(lk_q.evData))
    else $error("good safe word not stored");
  safe_reg_ok_a: assert property (safeEnd_s ##0 lk_q.crcOk && !lk_q.isRam
      |=> sy_q.regs[$past(lk_q.evAddr[REG_AW-1:0])] == $past(lk_q.evData[7:0]))
    else $error("good safe byte not stored");
  frame_error_a: assert property (frameEnd && lk_q.cmdKnown && !lk_q.crcDone && lk_q.cmd == CMD_WRITE_CRC
      |=> sy_q.framing)
    else $error("early deselect not flagged");
  read_noflag_a: assert property (endEv && lk_q.cmd == CMD_READ_CRC && !clearFlags |=> $stable(sy_q.mismatch))
    else $error("read changed mismatch flag");
  word_commit_a: assert property (byteEv && lk_q.isRam && lk_q.evAddr[1:0] == LANE_LAST
      |=> sy_q.ram[ramIdx($past(lk_q.evAddr))] == $past(lk_q.evData))
    else $error("full word not committed");
  partial_drop_a: assert property (byteEv && lk_q.isRam && lk_q.evAddr[1:0] != LANE_LAST && !endEv
      |=> $stable(sy_q.ram))
    else $error("partial word reached ram");
  crc_keep_ram_a: assert property (endEv && lk_q.cmd == CMD_WRITE_CRC && !lk_q.crcOk && !byteEv
      |=> $stable(sy_q.ram) && sy_q.mismatch)
    else $error("checked write mismatch handling wrong");
  fetch_align_a: assert property (fetchEv && lk_q.isRam |-> lk_q.fetchAddr[1:0] == WORD_ALIGN)
    else $error("unaligned ram fetch");
  flag_hold_a: assert property ($rose(sy_q.mismatch) && !clearFlags ##1 !clearFlags [*2] |-> sy_q.mismatch)
    else $error("mismatch flag lost");
endmodule

// >>> tb/sca_host_model.sv
// Host side serial master model for the checked access block
`timescale 1ns/100ps
module sca_host_model (
  // Serial link
  output logic      sck,
  output logic      chipSelectLow,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdoOe
);
  // Deselect edge just after start arms the frame start marker
  initial begin
    sck = 1'b0;
    chipSelectLow = 1'b0;
    sdi = 1'b0;
    #1 chipSelectLow = 1'b1;
  end

  // ==========================================================================
  // Checksum over a bit stream, preset at select
  function automatic logic [15:0] crcOf(input logic b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction

  // ==========================================================================
  // One frame: 12 ns sck, still outside frames, sdi toggles when unused
  task automatic frame(input logic tx[$], input int nClk, output logic [1:0] rx[$]);
    rx = {};
    chipSelectLow = 1'b0;
    #6;
    for (int i = 0; i < nClk; i++) begin
      sdi = (i < tx.size()) ? tx[i] : ~sdi;
      #6 sck = 1'b1;
      // Released line reads as the inverse of the driven bit
      rx.push_back({sdoOe, sdoOe ? sdo : ~sdo});
      #6 sck = 1'b0;
    end
    sdi = ~sdi;
    #60 chipSelectLow = 1'b1;
    #120;
  endtask
endmodule

// >>> tb/sca_access_top_bench.sv
// Self-checking bench for the checked access block
`timescale 1ns/100ps
module sca_access_top_bench;
  import sca_pkg::*;
  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  logic        clearFlags = 1'b0;
  logic        sck;
  logic        chipSelectLow;
  logic        sdi;
  logic        sdo;
  logic        sdoOe;
  logic        crcMismatchFlag;
  logic        crcFramingErrorFlag;
  logic [15:0] crcResult;
  logic [15:0] lastCrc;
  int          nErrors     = 0;
  int          comparisons = 0;
  logic [7:0]  wA[$] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'ha5, 8'h5a, 8'h0f, 8'hf0};
  logic [7:0]  wB[$] = '{8'hde, 8'had, 8'hbe, 8'hef};
  logic [7:0]  wZ[$] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00};

  always #5 clk = ~clk;

  sca_access_top dut (
    .clk                 (clk),
    .srst                (srst),
    .clearFlags          (clearFlags),
    .sck                 (sck),
    .chipSelectLow       (chipSelectLow),
    .sdi                 (sdi),
    .sdo                 (sdo),
    .sdoOe               (sdoOe),
    .crcMismatchFlag     (crcMismatchFlag),
    .crcFramingErrorFlag (crcFramingErrorFlag),
    .crcResult           (crcResult)
  );

  sca_host_model host (
    .sck           (sck),
    .chipSelectLow (chipSelectLow),
    .sdi           (sdi),
    .sdo           (sdo),
    .sdoOe         (sdoOe)
  );

  // ==========================================================================
  // Compare and report
  task automatic checkBit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic checkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("Mismatches %0d of %0d comparisons", nErrors, comparisons);
    if (nErrors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Frame helpers
  function automatic void put(ref logic q[$], input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      q.push_back(v[i]);
    end
  endfunction

  // Count below zero means no count field; cut stops after that many bits
  task automatic sendWrite(input logic [3:0] cmd, input logic [11:0] addr, input int cnt,
                           input logic [7:0] d[$], input logic bad, input int cut);
    logic       tx[$];
    logic [1:0] rx[$];
    put(tx, {cmd, addr}, 16);
    if (cnt >= 0) begin
      put(tx, {8'h00, cnt[7:0]}, 8);
    end
    foreach (d[i]) begin
      put(tx, {8'h00, d[i]}, 8);
    end
    lastCrc = host.crcOf(tx);
    put(tx, lastCrc ^ {15'h0000, bad}, 16);
    host.frame(tx, (cut > 0) ? cut : tx.size(), rx);
  endtask

  // Only whole words of RAM are judged
  task automatic readBack(input logic [11:0] addr, input int cnt, input logic [7:0] exp[$], input int cut);
    logic       tx[$];
    logic       sh[$];
    logic [1:0] rx[$];
    logic [7:0] b;
    logic [15:0] c;
    int         g;
    g = (addr >= RAM_FIRST && addr <= RAM_LAST) ? 4 : 1;
    put(tx, {CMD_READ_CRC, addr}, 16);
    put(tx, {8'h00, cnt[7:0]}, 8);
    sh = tx;
    foreach (exp[i]) begin
      put(sh, {8'h00, exp[i]}, 8);
    end
    host.frame(tx, (cut > 0) ? cut : sh.size() + 16, rx);
    foreach (exp[i]) begin
      if (24 + 8 * g * (i / g + 1) <= rx.size()) begin
        for (int k = 0; k < 8; k++) begin
          b = {b[6:0], rx[24 + 8 * i + k][0]};
        end
        checkVal("read byte", {8'h00, exp[i]}, {8'h00, b});
        checkBit("read enable", 1'b1, rx[24 + 8 * i][1]);
      end
    end
    if (cut == 0) begin
      for (int k = 0; k < 16; k++) begin
        c = {c[14:0], rx[sh.size() + k][0]};
      end
      checkVal("read checksum", host.crcOf(sh), c);
    end
    checkBit("idle enable", 1'b0, sdoOe);
  endtask

  task automatic expectFlags(input logic mis, input logic frm);
    checkBit("mismatch flag", mis, crcMismatchFlag);
    checkBit("framing flag", frm, crcFramingErrorFlag);
    @(negedge clk) clearFlags = 1'b1;
    @(negedge clk) clearFlags = 1'b0;
    @(negedge clk);
    checkBit("flags cleared", 1'b0, crcMismatchFlag | crcFramingErrorFlag);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic scnReset;
    checkBit("reset enable", 1'b0, sdoOe);
    checkVal("reset result", 16'h0000, crcResult);
    expectFlags(1'b0, 1'b0);
  endtask

  task automatic scnRamChecked;
    sendWrite(CMD_WRITE_CRC, 12'h403, 2, wA, 1'b0, 0);
    expectFlags(1'b0, 1'b0);
    readBack(12'h402, 2, wA, 0);
    expectFlags(1'b0, 1'b0);
  endtask

  task automatic scnRamBadCrc;
    sendWrite(CMD_WRITE_CRC, 12'h408, 1, wB, 1'b1, 0);
    checkVal("stored checksum", lastCrc, crcResult);
    expectFlags(1'b1, 1'b0);
    readBack(12'h408, 1, wB, 0);
    readBack(12'h400, 3, {wA, wB}, 0);
  endtask

  task automatic scnSafeRam;
    sendWrite(CMD_WRITE_SAFE, 12'h411, -1, wB, 1'b0, 0);
    expectFlags(1'b0, 1'b0);
    sendWrite(CMD_WRITE_SAFE, 12'h410, -1, wA[0:3], 1'b1, 0);
    checkVal("stored checksum", lastCrc, crcResult);
    expectFlags(1'b1, 1'b0);
    readBack(12'h410, 1, wB, 0);
  endtask

  task automatic scnSafeReg;
    sendWrite(CMD_WRITE_SAFE, 12'h005, -1, '{8'h5a}, 1'b0, 0);
    expectFlags(1'b0, 1'b0);
    sendWrite(CMD_WRITE_SAFE, 12'h005, -1, '{8'hc3}, 1'b1, 0);
    expectFlags(1'b1, 1'b0);
    sendWrite(4'h2, 12'h005, -1, '{8'h77}, 1'b0, 20);
    expectFlags(1'b0, 1'b0);
    readBack(12'h005, 1, '{8'h5a}, 0);
  endtask

  task automatic scnPartial;
    sendWrite(CMD_WRITE_CRC, 12'h420, 2, wA, 1'b0, 72);
    expectFlags(1'b0, 1'b1);
    readBack(12'h420, 2, wZ, 0);
    readBack(12'h420, 2, wZ, 72);
    expectFlags(1'b0, 1'b1);
    readBack(12'h420, 1, wZ[0:3], 68);
    expectFlags(1'b0, 1'b1);
  endtask

  // Reset in mid-run clears storage and status
  task automatic scnMidReset;
    srst = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    checkVal("mid reset result", 16'h0000, crcResult);
    readBack(12'h400, 1, wZ[4:7], 0);
    expectFlags(1'b0, 1'b0);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    scnReset();
    scnRamChecked();
    scnRamBadCrc();
    scnSafeRam();
    scnSafeReg();
    scnPartial();
    scnMidReset();
    give_verdict();
  end

  // Hang guard
  initial begin
    #500000;
    nErrors++;
    $display("CHECK FAILED run length expected done seen hang");
    give_verdict();
  end
endmodule
